// file: logic/glc_pkg.sv
package glc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RST = 8'h01;
  localparam logic [7:0] IDX_GCFG = 8'h02;
  localparam logic [7:0] IDX_TERM = 8'h03;
  localparam logic [7:0] IDX_JCFG = 8'h04;

  // Global config fields
  localparam int GCFG_STD_POS = 2;
  localparam int GCFG_INT_LSB = 0;

  // Termination fields
  localparam int TERM_TX_LSB = 3;
  localparam int TERM_RX_LSB = 0;

  // Jitter attenuator fields
  localparam int JCFG_LIMIT_POS = 5;
  localparam int JCFG_PLACE_LSB = 3;
  localparam int JCFG_DEPTH_LSB = 1;
  localparam int JCFG_BW_POS = 0;

  // Reset values
  localparam logic RST_LINE_STD = 1'h0;
  localparam logic [1:0] RST_INT_STYLE = 2'h0;
  localparam logic [2:0] RST_TX_TERM = 3'h0;
  localparam logic [2:0] RST_RX_TERM = 3'h0;
  localparam logic RST_LIMIT = 1'h1;
  localparam logic [1:0] RST_PLACE = 2'h0;
  localparam logic [1:0] RST_DEPTH = 2'h0;
  localparam logic RST_BW = 1'h0;

  // Attenuator placement codes
  localparam logic [1:0] PLACE_TX = 2'h1;
  localparam logic [1:0] PLACE_RX = 2'h3;

  // Elastic buffer depths in bits
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;

  // Settling time after a line standard change
  localparam int SETTLE_US = 50;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

endpackage

// file: logic/glc_regs.sv
`timescale 1ns/1ps
module glc_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic driver_release,
  output logic soft_reset_pulse,
  output logic driver_hiz,
  output logic line_t1,
  output logic int_open_drain,
  output logic int_active_high,
  output logic [1:0] tx_term_sel,
  output logic tx_term_external,
  output logic [1:0] rx_term_sel,
  output logic rx_term_external,
  output logic jitter_limit_mode_mode,
  output logic ja_in_tx,
  output logic ja_in_rx,
  output logic [7:0] ja_depth_bits,
  output logic ja_low_bw,
  output logic settle_busy
);

  initial begin
    if (ADDR_W < 5 || ADDR_W > 16) begin
      $error("glc_regs: ADDR_W must be 5 to 16");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [ADDR_W-3:0] word;
  logic aligned;
  logic hit_rst;
  logic hit_gcfg;
  logic hit_term;
  logic hit_jcfg;
  logic mapped;
  logic fire;
  logic wr_fire;
  logic soft_rst;

  assign word = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_rst = aligned && (word == (ADDR_W-2)'(glc_pkg::IDX_RST));
  assign hit_gcfg = aligned && (word == (ADDR_W-2)'(glc_pkg::IDX_GCFG));
  assign hit_term = aligned && (word == (ADDR_W-2)'(glc_pkg::IDX_TERM));
  assign hit_jcfg = aligned && (word == (ADDR_W-2)'(glc_pkg::IDX_JCFG));
  assign mapped = hit_rst || hit_gcfg || hit_term || hit_jcfg;
  assign fire = psel && penable && pready_ff;
  assign wr_fire = fire && pwrite && mapped;
  assign soft_rst = wr_fire && hit_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Field storage

  logic line_std_ff;
  logic [1:0] int_style_ff;
  logic [2:0] tx_term_ff;
  logic [2:0] rx_term_ff;
  logic limit_ff;
  logic [1:0] place_ff;
  logic [1:0] depth_ff;
  logic bw_ff;

  // Line standard survives soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_std_ff <= glc_pkg::RST_LINE_STD;
    end else if (wr_fire && hit_gcfg) begin
      line_std_ff <= pwdata[glc_pkg::GCFG_STD_POS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_style_ff <= glc_pkg::RST_INT_STYLE;
    end else if (soft_rst) begin
      int_style_ff <= glc_pkg::RST_INT_STYLE;
    end else if (wr_fire && hit_gcfg) begin
      int_style_ff <= pwdata[glc_pkg::GCFG_INT_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_term_ff <= glc_pkg::RST_TX_TERM;
      rx_term_ff <= glc_pkg::RST_RX_TERM;
    end else if (soft_rst) begin
      tx_term_ff <= glc_pkg::RST_TX_TERM;
      rx_term_ff <= glc_pkg::RST_RX_TERM;
    end else if (wr_fire && hit_term) begin
      tx_term_ff <= pwdata[glc_pkg::TERM_TX_LSB +: 3];
      rx_term_ff <= pwdata[glc_pkg::TERM_RX_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_ff <= glc_pkg::RST_LIMIT;
      place_ff <= glc_pkg::RST_PLACE;
      depth_ff <= glc_pkg::RST_DEPTH;
      bw_ff <= glc_pkg::RST_BW;
    end else if (soft_rst) begin
      limit_ff <= glc_pkg::RST_LIMIT;
      place_ff <= glc_pkg::RST_PLACE;
      depth_ff <= glc_pkg::RST_DEPTH;
      bw_ff <= glc_pkg::RST_BW;
    end else if (wr_fire && hit_jcfg) begin
      limit_ff <= pwdata[glc_pkg::JCFG_LIMIT_POS];
      place_ff <= pwdata[glc_pkg::JCFG_PLACE_LSB +: 2];
      depth_ff <= pwdata[glc_pkg::JCFG_DEPTH_LSB +: 2];
      bw_ff <= pwdata[glc_pkg::JCFG_BW_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state, then ready

  logic [31:0] nxt_prdata;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_gcfg) begin
      nxt_prdata[glc_pkg::GCFG_STD_POS] = line_std_ff;
      nxt_prdata[glc_pkg::GCFG_INT_LSB +: 2] = int_style_ff;
    end else if (hit_term) begin
      nxt_prdata[glc_pkg::TERM_TX_LSB +: 3] = tx_term_ff;
      nxt_prdata[glc_pkg::TERM_RX_LSB +: 3] = rx_term_ff;
    end else if (hit_jcfg) begin
      nxt_prdata[glc_pkg::JCFG_LIMIT_POS] = limit_ff;
      nxt_prdata[glc_pkg::JCFG_PLACE_LSB +: 2] = place_ff;
      nxt_prdata[glc_pkg::JCFG_DEPTH_LSB +: 2] = depth_ff;
      nxt_prdata[glc_pkg::JCFG_BW_POS] = bw_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      if (psel && penable && !pready_ff && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset effects and settle timer

  logic soft_pulse_ff;
  logic driver_hiz_ff;
  logic [$clog2(glc_pkg::SETTLE_CYC+1)-1:0] settle_cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_pulse_ff <= 1'b0;
    end else begin
      soft_pulse_ff <= soft_rst;
    end
  end

  // Set wins over release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_hiz_ff <= 1'b1;
    end else if (soft_rst) begin
      driver_hiz_ff <= 1'b1;
    end else if (driver_release) begin
      driver_hiz_ff <= 1'b0;
    end
  end

  // Counts the clocking settle time after a standard change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_ff <= '0;
    end else if (wr_fire && hit_gcfg && (pwdata[glc_pkg::GCFG_STD_POS] != line_std_ff)) begin
      settle_cnt_ff <= ($clog2(glc_pkg::SETTLE_CYC+1))'(glc_pkg::SETTLE_CYC);
    end else if (settle_cnt_ff != '0) begin
      settle_cnt_ff <= settle_cnt_ff - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls

  logic line_t1_ff, int_od_ff, int_ah_ff, tx_ext_ff, rx_ext_ff, limit_out_ff;
  logic ja_tx_ff, ja_rx_ff, low_bw_ff, settle_ff;
  logic [1:0] tx_sel_ff, rx_sel_ff;
  logic [7:0] depth_bits_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_t1_ff <= 1'b0;
      int_od_ff <= 1'b1;
      int_ah_ff <= 1'b0;
    end else begin
      line_t1_ff <= line_std_ff;
      int_od_ff <= !int_style_ff[0];
      int_ah_ff <= (int_style_ff == 2'h3);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sel_ff <= 2'h0;
      tx_ext_ff <= 1'b0;
      rx_sel_ff <= 2'h0;
      rx_ext_ff <= 1'b0;
    end else begin
      tx_sel_ff <= tx_term_ff[1:0];
      tx_ext_ff <= tx_term_ff[2] && !line_std_ff;
      rx_sel_ff <= rx_term_ff[1:0];
      rx_ext_ff <= rx_term_ff[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_out_ff <= 1'b1;
      ja_tx_ff <= 1'b0;
      ja_rx_ff <= 1'b0;
      depth_bits_ff <= glc_pkg::DEPTH_128;
      low_bw_ff <= 1'b0;
      settle_ff <= 1'b0;
    end else begin
      limit_out_ff <= limit_ff;
      ja_tx_ff <= (place_ff == glc_pkg::PLACE_TX);
      ja_rx_ff <= (place_ff == glc_pkg::PLACE_RX);
      if (depth_ff[1]) begin
        depth_bits_ff <= glc_pkg::DEPTH_32;
      end else if (depth_ff[0]) begin
        depth_bits_ff <= glc_pkg::DEPTH_64;
      end else begin
        depth_bits_ff <= glc_pkg::DEPTH_128;
      end
      low_bw_ff <= bw_ff;
      settle_ff <= (settle_cnt_ff != '0);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign soft_reset_pulse = soft_pulse_ff;
  assign driver_hiz = driver_hiz_ff;
  assign line_t1 = line_t1_ff;
  assign int_open_drain = int_od_ff;
  assign int_active_high = int_ah_ff;
  assign tx_term_sel = tx_sel_ff;
  assign tx_term_external = tx_ext_ff;
  assign rx_term_sel = rx_sel_ff;
  assign rx_term_external = rx_ext_ff;
  assign jitter_limit_mode_mode = limit_out_ff;
  assign ja_in_tx = ja_tx_ff;
  assign ja_in_rx = ja_rx_ff;
  assign ja_depth_bits = depth_bits_ff;
  assign ja_low_bw = low_bw_ff;
  assign settle_busy = settle_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  soft_defaults_a: assert property (soft_rst |=> (limit_ff && place_ff == 2'h0 && depth_ff == 2'h0
    && int_style_ff == 2'h0 && tx_term_ff == 3'h0 && rx_term_ff == 3'h0))
    else $error("soft reset left a field off default");
  rst_reads_zero_a: assert property (pready_ff && !pwrite && hit_rst |-> prdata_ff == 32'h0000_0000)
    else $error("reset register read nonzero");
  hiz_after_rst_a: assert property (soft_rst |=> driver_hiz_ff ##1 (driver_hiz || soft_pulse_ff))
    else $error("drivers not high impedance after soft reset");
  std_kept_a: assert property (soft_rst |=> line_std_ff == $past(line_std_ff))
    else $error("line standard lost on soft reset");
  std_output_a: assert property (wr_fire && hit_gcfg |=> ##1 line_t1 == $past(pwdata[2], 2))
    else $error("line standard output wrong");
  int_style_a: assert property (int_open_drain == !$past(int_style_ff[0])
    && int_active_high == ($past(int_style_ff) == 2'h3))
    else $error("interrupt style decode wrong");
  tx_term_a: assert property (tx_term_sel == $past(tx_term_ff[1:0]))
    else $error("transmit termination select wrong");
  tx_ext_a: assert property (tx_term_external |-> $past(tx_term_ff[2]) && !$past(line_std_ff))
    else $error("external transmit matching outside E1");
  rx_term_a: assert property (rx_term_external == $past(rx_term_ff[2]))
    else $error("receive termination decode wrong");
  limit_mode_a: assert property (jitter_limit_mode_mode == $past(limit_ff))
    else $error("limit mode output wrong");
  ja_place_a: assert property (!(ja_in_tx && ja_in_rx) && (ja_in_rx == ($past(place_ff) == 2'h3)))
    else $error("attenuator placement wrong");
  ja_depth_a: assert property ($past(depth_ff[1]) |-> ja_depth_bits == 8'h20)
    else $error("attenuator depth wrong");
  ja_bw_a: assert property (ja_low_bw == $past(bw_ff))
    else $error("bandwidth select wrong");
  settle_a: assert property (wr_fire && hit_gcfg && pwdata[2] != line_std_ff |=> ##1 settle_busy[*8])
    else $error("settle window not raised");

  soft_reset_c: cover property (soft_rst ##1 soft_pulse_ff);
  std_change_c: cover property (wr_fire && hit_gcfg ##2 line_t1);
  ja_rx_c: cover property (ja_in_rx && ja_depth_bits == 8'h40);
  unmapped_c: cover property (pslverr_ff);

endmodule

// file: testbench/glc_host.sv
`timescale 1ns/1ps
module glc_host (
  input wire logic pclk,
  input wire logic presetn,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  logic std_ff;

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'h0;
    std_ff = 1'h0;
  end

  // Hardware reset returns the tracked standard to its default
  always @(negedge presetn) begin
    std_ff = 1'h0;
  end

  ////////////////////////////////////////////////////////////////
  // One APB transfer, bounded wait for pready
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    if (n >= 40) begin
      hung <= 1'h1;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////
  // Register write with reserved bits cleared and settling wait
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic err;
    logic [7:0] m;
    m = (idx == glc_pkg::IDX_GCFG) ? 8'h07 : 8'h3F;
    xfer(1'h1, idx, {24'h0, d & m}, q, err);
    if (idx == glc_pkg::IDX_GCFG && d[2] != std_ff) begin
      std_ff = d[2];
      repeat (glc_pkg::SETTLE_CYC) @(posedge pclk);
    end
  endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, driver_release;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic soft_reset_pulse, driver_hiz, line_t1, int_open_drain, int_active_high;
  logic tx_term_external, rx_term_external, jitter_limit_mode_mode, ja_in_tx, ja_in_rx, ja_low_bw, settle_busy;
  logic [1:0] tx_term_sel, rx_term_sel;
  logic [7:0] ja_depth_bits;
  logic [31:0] rs = 32'h63;
  int num_errors = 0;
  int num_checks = 0;
  int pulses = 0;

  glc_regs glc_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .driver_release(driver_release), .soft_reset_pulse(soft_reset_pulse), .driver_hiz(driver_hiz),
    .line_t1(line_t1), .int_open_drain(int_open_drain), .int_active_high(int_active_high),
    .tx_term_sel(tx_term_sel), .tx_term_external(tx_term_external), .rx_term_sel(rx_term_sel),
    .rx_term_external(rx_term_external), .jitter_limit_mode_mode(jitter_limit_mode_mode), .ja_in_tx(ja_in_tx),
    .ja_in_rx(ja_in_rx), .ja_depth_bits(ja_depth_bits), .ja_low_bw(ja_low_bw), .settle_busy(settle_busy));
  glc_host glc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (soft_reset_pulse === 1'h1) pulses++;
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [7:0] exp_depth(input logic [1:0] c);
    return (c == 2'h0) ? 8'h80 : ((c == 2'h1) ? 8'h40 : 8'h20);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge hung) begin
    num_errors++;
    conclude();
  end

  // Decoded outputs and readback of the three config registers
  task automatic check_all(input logic [7:0] g, input logic [7:0] t, input logic [7:0] j);
    logic [31:0] q;
    logic err;
    repeat (2) @(posedge pclk);
    #1;
    chk("line_t1", line_t1, g[2]);
    chk("int_open_drain", int_open_drain, !g[0]);
    chk("int_active_high", int_active_high, g[1] & g[0]);
    chk("tx_term_sel", tx_term_sel, t[4:3]);
    chk("tx_term_external", tx_term_external, t[5] & !g[2]);
    chk("rx_term_sel", rx_term_sel, t[1:0]);
    chk("rx_term_external", rx_term_external, t[2]);
    chk("jitter_limit_mode_mode", jitter_limit_mode_mode, j[5]);
    chk("ja_in_tx", ja_in_tx, j[4:3] == 2'h1);
    chk("ja_in_rx", ja_in_rx, j[4:3] == 2'h3);
    chk("ja_depth_bits", ja_depth_bits, exp_depth(j[2:1]));
    chk("ja_low_bw", ja_low_bw, j[0]);
    glc_host_i.xfer(1'h0, glc_pkg::IDX_GCFG, 32'h0, q, err);
    chk("global_config", q, {24'h0, g});
    glc_host_i.xfer(1'h0, glc_pkg::IDX_TERM, 32'h0, q, err);
    chk("line_termination_config", q, {24'h0, t});
    glc_host_i.xfer(1'h0, glc_pkg::IDX_JCFG, 32'h0, q, err);
    chk("jitter_attenuator_config", q, {24'h0, j});
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, rnd;
    logic err;
    logic [7:0] g, t, j;
    int n;
    presetn = 1'h0;
    driver_release = 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    chk("driver_hiz", driver_hiz, 1'h1);
    check_all(8'h00, 8'h00, 8'h20);
    $display("test reset_values done");
    glc_host_i.xfer(1'h0, glc_pkg::IDX_RST, 32'h0, q, err);
    chk("reset_port_read", q, 32'h0);
    glc_host_i.xfer(1'h1, 8'h05, 32'hFF, q, err);
    chk("unmapped_err", err, 1'h1);
    glc_host_i.xfer(1'h0, 8'h00, 32'h0, q, err);
    chk("unmapped_err", err, 1'h1);
    check_all(8'h00, 8'h00, 8'h20);
    $display("test unmapped done");
    for (int i = 0; i < 8; i++) begin
      rnd = next_rnd();
      n = i;
      g = {5'h0, rnd[2], n[1:0]};
      t = {2'h0, n[2:0], n[2:0] ^ rnd[5:3]};
      j = {2'h0, rnd[6], n[1:0], n[2:1], rnd[7]};
      glc_host_i.wr(glc_pkg::IDX_GCFG, g);
      glc_host_i.wr(glc_pkg::IDX_TERM, t);
      glc_host_i.wr(glc_pkg::IDX_JCFG, j);
      check_all(g, t, j);
    end
    $display("test random_config done");
    glc_host_i.wr(glc_pkg::IDX_GCFG, 8'h07);
    glc_host_i.wr(glc_pkg::IDX_TERM, 8'h2D);
    glc_host_i.wr(glc_pkg::IDX_JCFG, 8'h1E);
    driver_release <= 1'h1;
    repeat (2) @(posedge pclk);
    #1;
    chk("driver_hiz_released", driver_hiz, 1'h0);
    @(posedge pclk);
    driver_release <= 1'h0;
    n = pulses;
    rnd = next_rnd();
    glc_host_i.wr(glc_pkg::IDX_RST, rnd[7:0]);
    check_all(8'h04, 8'h00, 8'h20);
    chk("line_t1_kept", line_t1, 1'h1);
    chk("driver_hiz", driver_hiz, 1'h1);
    chk("reset_pulses", pulses - n, 32'h1);
    $display("test soft_reset done");
    conclude();
  end
endmodule
